// >>> vc_regs.sv
// Purpose: Global violation counter access and pulse enable registers.
// Assumes: Simple synchronous byte bus; counters supplied as increments.
// Notes: Counters live here so clears and snapshots act on them.
//
// Operation
// - Byte select picks low or high byte
// - Channel snapshot copies count to holding
// - Channel clear zeroes addressed counter
// - Per-channel actions use channel select field
// - Count byte reads selected held byte
// - Custom pulse enable drives all channels in E1 mode
// - Read-only identity register
// - Upper pulse enable bits unused storage
// - Select zero none, one is channel 0
// - Clear-all zeroes every counter
// - Snapshot-all copies every counter
`timescale 1ns/10ps
`include "vc_regs_consts.svh"
module vc_regs #(
	parameter logic [7:0] DEVICE_IDENTITY = 8'h5A // Arbitrary value
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] i_violation, // Per-channel event pulse
	input wire logic i_e1_mode, // E1 operation active
	output logic [7:0] o_rdata,
	output logic [7:0] o_custom_pulse, // Per-channel shaping mode
	output logic [7:0] o_clear_held // Channel clear settled
);
	vc_regs_pkg::byte_t ch_select_r; // Select register
	vc_regs_pkg::byte_t cnt_ctrl_r; // Control register
	vc_regs_pkg::byte_t pulse_en_r; // Pulse enable register
	vc_regs_pkg::count_t count_r [8]; // Running counts
	vc_regs_pkg::count_t hold_r [8]; // Snapshots
	logic [5:0] clr_cyc_r; // Cycles a clear has been held
	vc_regs_pkg::byte_t rd_nxt;
	ch_sel_if sel();

	assign sel.code = ch_select_r[3:0];
	ch_sel_decode u_dec (.sel(sel));

	// Register writes; reserved bits store as plain read/write
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ch_select_r <= `RST_REG8;
			cnt_ctrl_r <= `RST_REG8;
			pulse_en_r <= `RST_REG8;
		end else if (i_wr) begin
			if (i_addr == `OFS_CH_SELECT) begin
				ch_select_r <= i_wdata;
			end else if (i_addr == `OFS_CNT_CTRL) begin
				cnt_ctrl_r <= i_wdata;
			end else if (i_addr == `OFS_PULSE_EN) begin
				pulse_en_r <= i_wdata;
			end
		end
	end

	// Count how long a clear bit has stood, saturating
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			clr_cyc_r <= 6'h00;
		end else if (cnt_ctrl_r[`BIT_CH_CLEAR] ||
			cnt_ctrl_r[`BIT_ALL_CLEAR]) begin
			if (clr_cyc_r != 6'h3F) begin
				clr_cyc_r <= clr_cyc_r + 6'h01;
			end
		end else begin
			clr_cyc_r <= 6'h00;
		end
	end

	// Per channel counters and holding registers
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_ch
			logic clr_me;
			logic snap_me;
			assign clr_me = cnt_ctrl_r[`BIT_ALL_CLEAR] ||
				(cnt_ctrl_r[`BIT_CH_CLEAR] && sel.mask[g]);
			assign snap_me = cnt_ctrl_r[`BIT_ALL_SNAP] ||
				(cnt_ctrl_r[`BIT_CH_SNAP] && sel.mask[g]);
			// Clear takes the counter to zero; saturate, never wrap
			always_ff @(posedge i_clk) begin
				if (i_sys_rst || clr_me) begin
					count_r[g] <= `RST_COUNT;
				end else if (i_violation[g] && count_r[g] != 16'hFFFF) begin
					count_r[g] <= count_r[g] + 16'h0001;
				end
			end
			// Holding register only moves on a snapshot request
			always_ff @(posedge i_clk) begin
				if (i_sys_rst) begin
					hold_r[g] <= `RST_COUNT;
				end else if (snap_me) begin
					hold_r[g] <= count_r[g];
				end
			end
			// Custom pulse per channel, every channel driven from the one enable bit in E1 mode
			always_ff @(posedge i_clk) begin
				if (i_sys_rst) begin
					o_custom_pulse[g] <= 1'b0;
				end else begin
					o_custom_pulse[g] <= i_e1_mode &&
						pulse_en_r[`BIT_CUSTOM_PULSE];
				end
			end
			// Reports that a clear has stood its full minimum time
			always_ff @(posedge i_clk) begin
				if (i_sys_rst) begin
					o_clear_held[g] <= 1'b0;
				end else begin
					o_clear_held[g] <= clr_me &&
						clr_cyc_r >= 6'(`CLR_HOLD_CYC);
				end
			end
		end
	endgenerate

	// Pick the held byte of the addressed channel
	function automatic vc_regs_pkg::byte_t pick_byte(
		input vc_regs_pkg::count_t v, input logic hi);
		pick_byte = hi ? v[15:8] : v[7:0];
	endfunction

	// Read decode; unmapped addresses read zero
	always_comb begin
		rd_nxt = 8'h00;
		if (i_addr == `OFS_CH_SELECT) begin
			rd_nxt = ch_select_r;
		end else if (i_addr == `OFS_CNT_CTRL) begin
			rd_nxt = cnt_ctrl_r;
		end else if (i_addr == `OFS_CNT_BYTE) begin
			if (sel.valid) begin
				rd_nxt = pick_byte(hold_r[3'(sel.code - 4'h1)],
					cnt_ctrl_r[`BIT_BYTE_SEL]);
			end
		end else if (i_addr == `OFS_PULSE_EN) begin
			rd_nxt = pulse_en_r;
		end else if (i_addr == `OFS_DEV_ID) begin
			rd_nxt = DEVICE_IDENTITY;
		end
	end

	// Read data registered, held between reads
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= rd_nxt;
		end
	end

	// Read strobe on the count byte, the first step of every count read
	sequence s_count_read;
		i_rd && i_addr == `OFS_CNT_BYTE;
	endsequence

	// Checks on the counter and holding paths
	a_clear_zeroes: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		cnt_ctrl_r[`BIT_ALL_CLEAR] |=> count_r[0] == 16'h0000)
		else $error("clear-all did not zero counter");
	a_hold_stable: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		!cnt_ctrl_r[`BIT_ALL_SNAP] && !cnt_ctrl_r[`BIT_CH_SNAP]
		|=> $stable(hold_r[0]))
		else $error("holding register moved without snapshot");
	a_snap_copy: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		cnt_ctrl_r[`BIT_ALL_SNAP] |=> hold_r[1] == $past(count_r[1]))
		else $error("snapshot-all missed copy");
	a_ch_clear: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(cnt_ctrl_r[0] && ch_select_r[3:0] == 4'h1)
		|=> count_r[0] == 16'h0000)
		else $error("channel clear missed");
	a_clear_held: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		!cnt_ctrl_r[`BIT_CH_CLEAR] && !cnt_ctrl_r[`BIT_ALL_CLEAR]
		|=> o_clear_held == 8'h00)
		else $error("clear reported held with no clear bit");

	// Checks on the read path
	a_id_read: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_rd && i_addr == `OFS_DEV_ID) |=> o_rdata == DEVICE_IDENTITY)
		else $error("identity read wrong");
	a_none_zero: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		s_count_read ##0 (ch_select_r[3:0] == 4'h0)
		|=> o_rdata == 8'h00)
		else $error("no channel must read zero");
	a_far_none: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		s_count_read ##0 (ch_select_r[3:0] > 4'h8)
		|=> o_rdata == 8'h00)
		else $error("unused select code must read zero");
	a_byte_pick: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		s_count_read ##0 (ch_select_r[3:0] == 4'h1 && cnt_ctrl_r[2])
		|=> o_rdata == $past(hold_r[0][15:8]))
		else $error("high byte select wrong");
	a_low_pick: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		s_count_read ##0 (ch_select_r[3:0] == 4'h1 && !cnt_ctrl_r[2])
		|=> o_rdata == $past(hold_r[0][7:0]))
		else $error("low byte select wrong");

	// Checks on the mode outputs
	a_pulse_mode: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_e1_mode && pulse_en_r[0]) |=> o_custom_pulse == 8'hFF)
		else $error("custom pulse not applied to all");
	a_pulse_off: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		!(i_e1_mode && pulse_en_r[0])
		|=> o_custom_pulse == 8'h00)
		else $error("custom pulse left on");
endmodule // vc_regs

// >>> vc_regs_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 8-bit register bank on a byte address, 20 MHz clock.
// Notes: Included by its bare name.
`ifndef VC_REGS_CONSTS_SVH
`define VC_REGS_CONSTS_SVH
`define OFS_CH_SELECT 8'h8C
`define OFS_CNT_CTRL 8'h8D
`define OFS_CNT_BYTE 8'h8E
`define OFS_PULSE_EN 8'hC0
`define OFS_DEV_ID 8'hFE
`define BIT_ALL_CLEAR 4
`define BIT_ALL_SNAP 3
`define BIT_BYTE_SEL 2
`define BIT_CH_SNAP 1
`define BIT_CH_CLEAR 0
`define BIT_CUSTOM_PULSE 0
`define RST_REG8 8'h00
`define RST_COUNT 16'h0000
`define CLR_HOLD_NS 1000
`define CLK_PERIOD_NS 50
`define CLR_HOLD_CYC ((`CLR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> vc_regs_pkg.sv
// Purpose: Types shared by the register bank and its helper.
// Assumes: Eight channels, 16-bit counts.
// Notes: Constants live in the header.
package vc_regs_pkg;
	typedef logic [15:0] count_t;
	typedef logic [7:0] byte_t;
	typedef logic [7:0] ch_mask_t;
endpackage

// >>> ch_sel_if.sv
// Purpose: Carries decoded channel select between the two modules.
// Assumes: One clock domain.
// Notes: Bank drives the code, decoder returns the mask.
`timescale 1ns/10ps
interface ch_sel_if;
	logic [3:0] code; // Raw select field
	vc_regs_pkg::ch_mask_t mask; // One-hot channel, zero for none
	logic valid; // A channel is named
	modport bank (output code, input mask, input valid);
	modport dec (input code, output mask, output valid);
endinterface

// >>> ch_sel_decode.sv
// Purpose: Decodes the four-bit channel select field.
// Assumes: Codes 1..8 name channels 0..7.
// Notes: Codes above 8 select nothing.
`timescale 1ns/10ps
module ch_sel_decode (
	ch_sel_if.dec sel
);
	// Zero selects none; code n selects channel n-1
	always_comb begin
		sel.mask = 8'h00;
		sel.valid = 1'b0;
		if (sel.code >= 4'h1 && sel.code <= 4'h8) begin
			sel.mask = 8'h01 << (sel.code - 4'h1);
			sel.valid = 1'b1;
		end
	end
endmodule // ch_sel_decode

// >>> violation_counter_access_regs_tb.sv
// Purpose: Self-checking bench for the violation counter register bank.
// Assumes: Inputs change 1 ns after the rising edge; reads held in o_rdata.
// Notes: Clear bits are held 22 cycles, past the one microsecond (20 cycles) at 20 MHz.
`timescale 1ns/10ps
module violation_counter_access_regs_tb;
	logic i_clk = 1'b0; // 20 MHz system clock
	logic i_sys_rst = 1'b1; // Held for 6 cycles at start
	logic i_wr = 1'b0, i_rd = 1'b0, i_e1_mode = 1'b0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_violation = 8'h00;
	logic [7:0] o_rdata, o_custom_pulse, o_clear_held;
	int failures = 0, tests_run = 0; // Mismatches and comparisons

	// Identity is an arbitrary value so the read-only path is exercised
	vc_regs #(.DEVICE_IDENTITY(8'hA7)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_violation(i_violation), .i_e1_mode(i_e1_mode),
		.o_rdata(o_rdata), .o_custom_pulse(o_custom_pulse),
		.o_clear_held(o_clear_held));

	// Clock, 50 ns period
	initial begin
		forever #25 i_clk = ~i_clk;
	end

	// Advance n edges, then step off the edge so drives never race it
	task step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	// One byte compare; case inequality so unknowns never match
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Single-cycle write strobe, then one idle edge so a following
	// call never lowers and raises the strobe in one time step
	task wr(input logic [7:0] a, input logic [7:0] v);
		i_addr = a;
		i_wdata = v;
		i_wr = 1'b1;
		step(1);
		i_wr = 1'b0;
		step(1);
	endtask

	// Read, then wait one more edge; data stands until the next read
	task rdchk(input logic [7:0] a, input logic [7:0] exp);
		i_addr = a;
		i_rd = 1'b1;
		step(1);
		i_rd = 1'b0;
		step(1);
		chk($sformatf("read %h", a), exp, o_rdata);
	endtask

	// Violation events on the masked channels for n cycles
	task hits(input logic [7:0] m, input int n);
		i_violation = m;
		step(n);
		i_violation = 8'h00;
		step(1);
	endtask

	// Snapshot the selected channel, keeping the byte select given
	task snap(input logic [7:0] sel);
		wr(8'h8D, sel | 8'h02);
		wr(8'h8D, sel);
	endtask

	// Reset values, identity, read-only and unmapped places
	task t_reset;
		rdchk(8'h8C, 8'h00);
		rdchk(8'h8D, 8'h00);
		rdchk(8'h8E, 8'h00);
		rdchk(8'hC0, 8'h00);
		rdchk(8'hFE, 8'hA7);
		wr(8'hFE, 8'h00);
		rdchk(8'hFE, 8'hA7);
		rdchk(8'h10, 8'h00);
	endtask

	// Count 0x103 on channel 2 and 5 on channel 0, read both bytes
	task t_snap;
		wr(8'h8C, 8'h03);
		hits(8'h04, 254);
		hits(8'h05, 5);
		snap(8'h00);
		rdchk(8'h8E, 8'h03);
		wr(8'h8D, 8'h04);
		rdchk(8'h8E, 8'h01);
		hits(8'h04, 3);
		rdchk(8'h8E, 8'h01);
		wr(8'h8D, 8'h00);
		rdchk(8'h8E, 8'h03);
		wr(8'h8C, 8'h01);
		snap(8'h00);
		rdchk(8'h8E, 8'h05);
	endtask

	// Per-channel clear held one microsecond leaves other channels alone
	task t_clear;
		wr(8'h8C, 8'h03);
		wr(8'h8D, 8'h01);
		step(20);
		chk("clear held", 8'h04, o_clear_held);
		wr(8'h8D, 8'h00);
		chk("clear held", 8'h00, o_clear_held);
		snap(8'h00);
		rdchk(8'h8E, 8'h00);
		wr(8'h8C, 8'h01);
		snap(8'h00);
		rdchk(8'h8E, 8'h05);
	endtask

	// Clear all, then snapshot all and read through the select
	task t_all;
		wr(8'h8D, 8'h10);
		step(20);
		chk("clear held", 8'hFF, o_clear_held);
		wr(8'h8D, 8'h00);
		hits(8'h02, 7);
		wr(8'h8D, 8'h08);
		wr(8'h8D, 8'h00);
		wr(8'h8C, 8'h02);
		rdchk(8'h8E, 8'h07);
		wr(8'h8C, 8'h01);
		rdchk(8'h8E, 8'h00);
		wr(8'h8C, 8'h00);
		rdchk(8'h8E, 8'h00);
		wr(8'h8C, 8'h0A);
		rdchk(8'h8E, 8'h00);
	endtask

	// Custom pulse follows E1 mode and bit 0; upper bits only store
	task t_pulse;
		i_e1_mode = 1'b1;
		wr(8'hC0, 8'hFF);
		step(2);
		chk("pulse", 8'hFF, o_custom_pulse);
		rdchk(8'hC0, 8'hFF);
		i_e1_mode = 1'b0;
		step(2);
		chk("pulse", 8'h00, o_custom_pulse);
		i_e1_mode = 1'b1;
		wr(8'hC0, 8'hFE);
		step(2);
		chk("pulse", 8'h00, o_custom_pulse);
	endtask

	// Counts, then the single verdict
	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected 21 us of traffic
	initial begin
		#200000;
		failures++;
		print_verdict();
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge i_clk);
		#1;
		i_sys_rst = 1'b0;
		t_reset();
		t_snap();
		t_clear();
		t_all();
		t_pulse();
		print_verdict();
	end
endmodule // violation_counter_access_regs_tb
